// file: include/adcsq_consts.svh
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADCSQ_ADDR_UNUSED_A 6'h29
`define ADCSQ_ADDR_UNUSED_B 6'h2A
`define ADCSQ_ADDR_CTRL 6'h2B
`define ADCSQ_ADDR_DELAYS 6'h2C
`define ADCSQ_ADDR_CHMAP 6'h2D

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADCSQ_CTRL_RST 24'h000000
`define ADCSQ_DELAYS_RST 24'h000000
`define ADCSQ_CHMAP_RST 24'h000000
`define ADCSQ_UNUSED_VAL 24'h000000

// ----------------------------------------
// Field positions, sequencer_control
// ----------------------------------------
`define ADCSQ_ADC_WAKE_BIT 0
`define ADCSQ_GP_REQ_BIT 1
`define ADCSQ_GP_CONT_BIT 2
`define ADCSQ_GP_PAUSE_BIT 3
`define ADCSQ_GP_LAST_LSB 4
`define ADCSQ_LED_MANUAL_BIT 8
`define ADCSQ_TOUCH_WAKE_BIT 12
`define ADCSQ_TOUCH_REQ_BIT 13
`define ADCSQ_TOUCH_CONT_BIT 14
`define ADCSQ_TOUCH_PAUSE_BIT 15
`define ADCSQ_TOUCH_LAST_LSB 16
`define ADCSQ_PEN_DETECT_BIT 20

// ----------------------------------------
// Field positions, sequencer_delays
// ----------------------------------------
`define ADCSQ_GP_PRE_LSB 0
`define ADCSQ_GP_INTER_LSB 4
`define ADCSQ_GP_POST_LSB 8
`define ADCSQ_TOUCH_PRE_LSB 12
`define ADCSQ_TOUCH_INTER_LSB 16
`define ADCSQ_TOUCH_POST_LSB 20

// ----------------------------------------
// Slot map and timing
// ----------------------------------------
`define ADCSQ_MAPPED_SLOTS 6
`define ADCSQ_DLY_UNIT_NS 1000
`define ADCSQ_CLK_MHZ 25
`define ADCSQ_DLY_TICK_CYC ((`ADCSQ_DLY_UNIT_NS * `ADCSQ_CLK_MHZ) / 1000)

`endif

// file: include/adcsq_pkg.sv
package adcsq_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PRE,
        ST_CONV,
        ST_WAIT,
        ST_GAP,
        ST_POST
    } adcsq_state_type;

    typedef logic [23:0] adcsq_word_type;
    typedef logic [5:0] adcsq_addr_type;
    typedef logic [2:0] adcsq_slot_type;
    typedef logic [3:0] adcsq_nib_type;

endpackage

// file: include/adcsq_dly_if.sv
`timescale 1ns/1ps

// Link between the sequencer and its delay timer
interface adcsq_dly_if;
    logic load;
    logic [3:0] value;
    logic tick;
    logic done;
    modport ctrl (output load, output value, output tick, input done);
    modport timer (input load, input value, input tick, output done);
endinterface

// file: src/adcsq_delay.sv
`timescale 1ns/1ps

module adcsq_delay (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Control
    adcsq_dly_if.timer dly
);
    import adcsq_pkg::*;

    adcsq_nib_type cnt_q;
    logic run_q;

    // ----------------------------------------
    // Delay counter
    // ----------------------------------------
    // Counts delay-unit ticks; a value of zero ends on the cycle after load.
    // Done stands from zero until the next load, so a pause cannot swallow it.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt_q <= 4'h0;
            run_q <= 1'b0;
        end else if (dly.load) begin
            cnt_q <= dly.value;
            run_q <= 1'b1;
        end else if (run_q && dly.tick && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    assign dly.done = run_q && cnt_q == 4'h0;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_dly_load;
        @(posedge i_clk) disable iff (!i_rstn)
        dly.load |=> run_q && cnt_q == $past(dly.value);
    endproperty
    a_dly_load: assert property (p_dly_load) else $error("delay not loaded");

    property p_dly_hold;
        @(posedge i_clk) disable iff (!i_rstn)
        run_q && !dly.load && !dly.tick && cnt_q != 4'h0 |=> $stable(cnt_q) && run_q;
    endproperty
    a_dly_hold: assert property (p_dly_hold) else $error("delay moved without tick");

    property p_dly_stand;
        @(posedge i_clk) disable iff (!i_rstn)
        dly.done && !dly.load |=> dly.done;
    endproperty
    a_dly_stand: assert property (p_dly_stand) else $error("delay end lost");
endmodule

// file: src/adcsq_top.sv
`timescale 1ns/1ps
`include "adcsq_consts.svh"

// Summary of operation
// - Wake bit powers up the converter
// - Request bit starts general-purpose sequence
// - Continuous bit repeats general sequence
// - Touch request wins over general request
// - General pause freezes the general sequencer
// - Start at slot zero, stop after last
// - LED bit enables manual LED control
// - Touch wake bit powers up touch function
// - Touch request bit starts touch sequence
// - Touch continuous bit repeats touch sequence
// - Touch pause freezes the touch sequencer
// - Touch last slot set independently
// - Pre-delay before general readings begin
// - Inter-delay between successive general readings
// - Post-delay only between continuous general wraps
// - Touch has own pre, inter, post delays
// - Slot fields pick channel per result slot
// - Two unused locations read zero
module adcsq_top #(
    parameter int DLY_TICK_CYC = `ADCSQ_DLY_TICK_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Register port from the serial interface
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire adcsq_pkg::adcsq_addr_type i_addr,
    input wire adcsq_pkg::adcsq_word_type i_wdata,
    output adcsq_pkg::adcsq_word_type o_rdata,
    // Channels for slots 6 and 7, held elsewhere
    input wire logic [7:0] i_ext_channel_select,
    // Converter
    input wire logic i_conv_done,
    output logic o_conv_start,
    output adcsq_pkg::adcsq_slot_type o_conv_slot,
    output adcsq_pkg::adcsq_nib_type o_conv_channel,
    output logic o_conv_touch,
    output logic o_result_write,
    // Power and mode levels
    output logic o_adc_wake,
    output logic o_touch_wake,
    output logic o_pen_detect,
    output logic o_led_manual,
    output logic o_busy
);
    import adcsq_pkg::*;

    generate
        if (DLY_TICK_CYC < 1 || DLY_TICK_CYC > 65536) begin : g_bad_tick
            $error("DLY_TICK_CYC must lie in 1..65536");
        end
    endgenerate

    adcsq_word_type ctrl_q, ctrl_d;
    adcsq_word_type dly_q;
    adcsq_word_type map_q;
    adcsq_word_type rdata_q;
    adcsq_state_type state_q, state_d;
    adcsq_slot_type slot_q;
    adcsq_nib_type chan_q;
    logic touch_q;
    logic [15:0] div_q;
    logic tick;
    logic take_gp, take_touch;
    logic paused, cont, is_last, yield;
    adcsq_slot_type last_slot;
    adcsq_nib_type pre_v, inter_v, post_v;

    adcsq_dly_if dly ();

    adcsq_delay u_delay (
        .i_clk (i_clk),
        .i_rstn (i_rstn),
        .dly (dly)
    );

    // ----------------------------------------
    // Delay-unit divider
    // ----------------------------------------
    // One-cycle enable per delay unit
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            div_q <= 16'h0000;
        end else if (div_q == 16'(DLY_TICK_CYC - 1)) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    assign tick = div_q == 16'(DLY_TICK_CYC - 1);

    // ----------------------------------------
    // Active sequence settings
    // ----------------------------------------
    // Both sequences share one engine; touch_q picks which field set steers it
    always_comb begin
        if (touch_q) begin
            paused = ctrl_q[`ADCSQ_TOUCH_PAUSE_BIT];
            cont = ctrl_q[`ADCSQ_TOUCH_CONT_BIT];
            last_slot = ctrl_q[`ADCSQ_TOUCH_LAST_LSB +: 3];
            pre_v = dly_q[`ADCSQ_TOUCH_PRE_LSB +: 4];
            inter_v = dly_q[`ADCSQ_TOUCH_INTER_LSB +: 4];
            post_v = dly_q[`ADCSQ_TOUCH_POST_LSB +: 4];
        end else begin
            paused = ctrl_q[`ADCSQ_GP_PAUSE_BIT];
            cont = ctrl_q[`ADCSQ_GP_CONT_BIT];
            last_slot = ctrl_q[`ADCSQ_GP_LAST_LSB +: 3];
            pre_v = dly_q[`ADCSQ_GP_PRE_LSB +: 4];
            inter_v = dly_q[`ADCSQ_GP_INTER_LSB +: 4];
            post_v = dly_q[`ADCSQ_GP_POST_LSB +: 4];
        end
    end

    assign is_last = slot_q == last_slot;
    // A pending touch request ends a continuous general run at its wrap
    assign yield = !touch_q && ctrl_q[`ADCSQ_TOUCH_REQ_BIT];

    // Requests are taken only while the converter is awake
    assign take_touch = state_q == ST_IDLE && ctrl_q[`ADCSQ_ADC_WAKE_BIT]
        && ctrl_q[`ADCSQ_TOUCH_REQ_BIT];
    assign take_gp = state_q == ST_IDLE && ctrl_q[`ADCSQ_ADC_WAKE_BIT]
        && ctrl_q[`ADCSQ_GP_REQ_BIT] && !ctrl_q[`ADCSQ_TOUCH_REQ_BIT];

    // ----------------------------------------
    // Sequencer next state
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        dly.load = 1'b0;
        dly.value = pre_v;
        unique case (state_q)
            ST_IDLE: begin
                if (take_touch || take_gp) begin
                    state_d = ST_PRE;
                    dly.load = 1'b1;
                    dly.value = take_touch ? dly_q[`ADCSQ_TOUCH_PRE_LSB +: 4]
                                           : dly_q[`ADCSQ_GP_PRE_LSB +: 4];
                end
            end
            ST_PRE, ST_GAP, ST_POST: begin
                if (dly.done && !paused) begin
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                if (!paused) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (i_conv_done) begin
                    if (!is_last) begin
                        state_d = ST_GAP;
                        dly.load = 1'b1;
                        dly.value = inter_v;
                    end else if (cont && !yield) begin
                        state_d = ST_POST;
                        dly.load = 1'b1;
                        dly.value = post_v;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end
        endcase
    end

    // Delay time stops while the active sequence is paused
    assign dly.tick = tick && !paused;

    // ----------------------------------------
    // Sequencer state and slot
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_q <= ST_IDLE;
            slot_q <= 3'h0;
            touch_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (take_touch || take_gp) begin
                touch_q <= take_touch;
                slot_q <= 3'h0;
            end else if (state_q == ST_WAIT && i_conv_done) begin
                // Slot moves on entry to a delay so the channel settles before use
                slot_q <= is_last ? 3'h0 : slot_q + 3'h1;
            end
        end
    end

    // ----------------------------------------
    // Channel for the current slot
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            chan_q <= 4'h0;
        end else if (slot_q < 3'(`ADCSQ_MAPPED_SLOTS)) begin
            chan_q <= map_q[{slot_q, 2'b00} +: 4];
        end else begin
            chan_q <= i_ext_channel_select[{slot_q[0], 2'b00} +: 4];
        end
    end

    // ----------------------------------------
    // Control register write and request clear
    // ----------------------------------------
    // A host write in the same cycle wins over the self-clear
    always_comb begin
        ctrl_d = ctrl_q;
        if (take_touch) begin
            ctrl_d[`ADCSQ_TOUCH_REQ_BIT] = 1'b0;
        end
        if (take_gp) begin
            ctrl_d[`ADCSQ_GP_REQ_BIT] = 1'b0;
        end
        if (i_wr_en && i_addr == `ADCSQ_ADDR_CTRL) begin
            ctrl_d = i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ctrl_q <= `ADCSQ_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Delay and channel-map registers
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            dly_q <= `ADCSQ_DELAYS_RST;
            map_q <= `ADCSQ_CHMAP_RST;
        end else if (i_wr_en) begin
            if (i_addr == `ADCSQ_ADDR_DELAYS) begin
                dly_q <= i_wdata;
            end
            if (i_addr == `ADCSQ_ADDR_CHMAP) begin
                map_q <= i_wdata;
            end
        end
    end

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    // Read data lands the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rdata_q <= 24'h000000;
        end else if (i_rd_en) begin
            unique case (i_addr)
                `ADCSQ_ADDR_UNUSED_A: rdata_q <= `ADCSQ_UNUSED_VAL;
                `ADCSQ_ADDR_UNUSED_B: rdata_q <= `ADCSQ_UNUSED_VAL;
                `ADCSQ_ADDR_CTRL: rdata_q <= ctrl_q;
                `ADCSQ_ADDR_DELAYS: rdata_q <= dly_q;
                `ADCSQ_ADDR_CHMAP: rdata_q <= map_q;
                default: rdata_q <= 24'h000000;
            endcase
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_rdata = rdata_q;
    assign o_conv_start = state_q == ST_CONV && !paused;
    assign o_result_write = state_q == ST_WAIT && i_conv_done;
    assign o_conv_slot = slot_q;
    assign o_conv_channel = chan_q;
    assign o_conv_touch = touch_q;
    assign o_busy = state_q != ST_IDLE;
    // Pen detect is passed on as written; keeping wake off is the host's job
    assign o_adc_wake = ctrl_q[`ADCSQ_ADC_WAKE_BIT];
    assign o_touch_wake = ctrl_q[`ADCSQ_TOUCH_WAKE_BIT];
    assign o_pen_detect = ctrl_q[`ADCSQ_PEN_DETECT_BIT];
    assign o_led_manual = ctrl_q[`ADCSQ_LED_MANUAL_BIT];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_wake;
        @(posedge i_clk) disable iff (!i_rstn)
        i_wr_en && i_addr == `ADCSQ_ADDR_CTRL |=> o_adc_wake == $past(i_wdata[0])
            && o_touch_wake == $past(i_wdata[12]);
    endproperty
    a_wake: assert property (p_wake) else $error("wake level wrong");

    property p_led;
        @(posedge i_clk) disable iff (!i_rstn)
        i_wr_en && i_addr == `ADCSQ_ADDR_CTRL |=> o_led_manual == $past(i_wdata[8]);
    endproperty
    a_led: assert property (p_led) else $error("led override wrong");

    property p_prio;
        @(posedge i_clk) disable iff (!i_rstn)
        state_q == ST_IDLE && o_adc_wake && ctrl_q[1] && ctrl_q[13]
            |=> state_q == ST_PRE && o_conv_touch && ctrl_q[1];
    endproperty
    a_prio: assert property (p_prio) else $error("touch did not win");

    property p_first_slot;
        @(posedge i_clk) disable iff (!i_rstn)
        take_gp |=> o_conv_slot == 3'h0 ##0 (o_busy throughout (!o_conv_start [*1]));
    endproperty
    a_first_slot: assert property (p_first_slot) else $error("not at slot zero");

    property p_wrap;
        @(posedge i_clk) disable iff (!i_rstn)
        o_result_write && is_last && cont && !yield |=> state_q == ST_POST && o_conv_slot == 3'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap in continuous mode");

    property p_single;
        @(posedge i_clk) disable iff (!i_rstn)
        o_result_write && is_last && !cont |=> !o_busy ##1 (!o_busy || $past(take_gp || take_touch));
    endproperty
    a_single: assert property (p_single) else $error("single pass did not stop");

    property p_gap;
        @(posedge i_clk) disable iff (!i_rstn)
        o_result_write && !is_last |=> state_q == ST_GAP && o_conv_slot == $past(o_conv_slot) + 3'h1;
    endproperty
    a_gap: assert property (p_gap) else $error("inter delay skipped");

    property p_pause;
        @(posedge i_clk) disable iff (!i_rstn)
        paused && state_q != ST_IDLE |-> !o_conv_start ##1 (state_q != ST_WAIT || $past(state_q) == ST_WAIT);
    endproperty
    a_pause: assert property (p_pause) else $error("ran while paused");

    property p_channel;
        @(posedge i_clk) disable iff (!i_rstn)
        o_conv_start && o_conv_slot < 3'h6 |-> o_conv_channel == map_q[{o_conv_slot, 2'b00} +: 4];
    endproperty
    a_channel: assert property (p_channel) else $error("wrong channel for slot");

    property p_unused;
        @(posedge i_clk) disable iff (!i_rstn)
        i_rd_en && (i_addr == `ADCSQ_ADDR_UNUSED_A || i_addr == `ADCSQ_ADDR_UNUSED_B) |=> o_rdata == 24'h000000;
    endproperty
    a_unused: assert property (p_unused) else $error("unused location not zero");

    property p_reset;
        @(posedge i_clk)
        $rose(i_rstn) |-> ctrl_q == 24'h000000 && dly_q == 24'h000000 && !o_busy;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule

// file: verif/adcsq_conv_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Converter model
// ----------------------------------------
module adcsq_conv_model (
    // Clock
    input wire logic i_clk,
    // Converter side of the sequencer
    input wire logic i_start,
    input wire logic [3:0] i_lat,
    output logic o_done
);
    logic [3:0] cnt_q = 4'h0;

    // Latency restarts on each start; no reset, so a stale done may land in idle
    always @(posedge i_clk) begin
        if (i_start === 1'b1) begin
            cnt_q <= i_lat;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    // One-cycle done pulse, driven off the sampling edge
    always @(negedge i_clk) begin
        o_done <= (cnt_q == 4'h1);
    end
endmodule

// file: verif/adc_sequencer_control_test.sv
`timescale 1ns/1ps
`include "adcsq_consts.svh"

// ----------------------------------------
// Bench for the sequencer control block
// ----------------------------------------
module adc_sequencer_control_test;
    import adcsq_pkg::*;
    localparam int TICK = 2;
    logic clk, rstn, wr_en, rd_en, done, start, touch, rwr, adw, tw, pen, led, busy;
    adcsq_addr_type addr;
    adcsq_word_type wdata, rdata, d;
    logic [7:0] ext;
    logic [3:0] lat, chan;
    adcsq_slot_type slot;
    int error_cnt = 0, comparisons = 0, cyc = 0, st_q[$], dn_q[$], b[3], g[3];
    logic [7:0] res_q[$];
    logic [3:0] dv[3];

    adcsq_top #(.DLY_TICK_CYC(TICK)) adcsq_top_i (.i_clk(clk), .i_rstn(rstn), .i_wr_en(wr_en),
        .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_ext_channel_select(ext),
        .i_conv_done(done), .o_conv_start(start), .o_conv_slot(slot), .o_conv_channel(chan),
        .o_conv_touch(touch), .o_result_write(rwr), .o_adc_wake(adw), .o_touch_wake(tw),
        .o_pen_detect(pen), .o_led_manual(led), .o_busy(busy));
    adcsq_conv_model adcsq_conv_model_i (.i_clk(clk), .i_start(start), .i_lat(lat), .o_done(done));

    // Clock and converter latency, varied every cycle
    always #20 clk = ~clk;
    always @(negedge clk) lat <= 4'(1 + $urandom % 4);

    // Monitor; also cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (start === 1'b1) st_q.push_back(cyc);
        if (rwr === 1'b1) begin
            dn_q.push_back(cyc);
            res_q.push_back({touch, slot, chan});
        end
        if (cyc > 40000) begin
            error_cnt++;
            stop_test();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input adcsq_addr_type a, input adcsq_word_type v);
        @(negedge clk);
        wr_en = 1; addr = a; wdata = v;
        @(negedge clk);
        wr_en = 0;
    endtask
    // Data is registered; sampled one and a half cycles after the read edge
    task automatic rd(input adcsq_addr_type a, output adcsq_word_type v);
        @(negedge clk);
        rd_en = 1; addr = a;
        @(negedge clk);
        rd_en = 0;
        @(negedge clk);
        v = rdata;
    endtask
    task automatic rst_pulse();
        @(negedge clk);
        rstn = 0;
        repeat (3) @(negedge clk);
        rstn = 1;
    endtask
    task automatic wait_n(input int n);
        st_q.delete(); dn_q.delete(); res_q.delete();
        for (int k = 0; k < 3000 && res_q.size() < n; k++) @(negedge clk);
    endtask
    function automatic logic [3:0] exp_ch(logic [23:0] m, logic [7:0] e, int s);
        return (s < 6) ? m[s*4+:4] : e[(s-6)*4+:4];
    endfunction
    function automatic logic [23:0] in_rng(int df, int n);
        return 24'(df >= (n - 1) * TICK && df <= (n + 1) * TICK + 2);
    endfunction
    // Continuous pass over slots 0..1, then a reset in mid-run
    task automatic dly_run(input bit t, output int o[3]);
        int c0;
        wr(`ADCSQ_ADDR_DELAYS, {dv[2], dv[1], dv[0]} << (t ? 12 : 0));
        c0 = cyc;
        fork
            wait_n(3);
            wr(`ADCSQ_ADDR_CTRL, t ? 24'h017001 : 24'h000017);
        join
        o[0] = st_q[0] - c0;
        o[1] = st_q[1] - dn_q[0];
        o[2] = st_q[2] - dn_q[1];
        chk({17'h0, res_q[0][7], res_q[1][6:4], res_q[2][6:4]}, {17'h0, t, 6'h08});
        rst_pulse();
        rd(`ADCSQ_ADDR_DELAYS, d);
        chk({d[22:0], busy}, 24'h0);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        clk = 0; rstn = 0; wr_en = 0; rd_en = 0; addr = 0; wdata = 0; ext = 0; lat = 1;
        void'($urandom(657));
        repeat (3) @(negedge clk);
        rstn = 1;
        for (int a = 'h29; a <= 'h2D; a++) begin
            rd(6'(a), d);
            chk(d, 24'h0);
        end
        chk({19'h0, adw, tw, pen, led, busy}, 24'h0);
        for (int i = 0; i < 6; i++) begin
            wdata = 24'($urandom);
            wr(`ADCSQ_ADDR_CHMAP, wdata);
            rd(`ADCSQ_ADDR_CHMAP, d);
            chk(d, wdata);
            wr(`ADCSQ_ADDR_DELAYS, 24'(i * 24'h111111));
            rd(`ADCSQ_ADDR_DELAYS, d);
            chk(d, 24'(i * 24'h111111));
            wdata = 24'($urandom) & 24'hFFDFFD;
            if (wdata[20]) wdata[12] = 0;
            d = wdata;
            wr(`ADCSQ_ADDR_CTRL, d);
            rd(`ADCSQ_ADDR_CTRL, wdata);
            chk(wdata, d);
            chk({20'h0, adw, tw, pen, led}, {20'h0, d[0], d[12], d[20], d[8]});
            wr(i[0] ? `ADCSQ_ADDR_UNUSED_A : (i[1] ? `ADCSQ_ADDR_UNUSED_B : 6'h3F), 24'($urandom));
            rd(i[0] ? `ADCSQ_ADDR_UNUSED_A : (i[1] ? `ADCSQ_ADDR_UNUSED_B : 6'h3F), d);
            chk(d, 24'h0);
        end
        wr(`ADCSQ_ADDR_CTRL, 24'h0);
        wr(`ADCSQ_ADDR_DELAYS, 24'h0);
        $display("test registers done");
        // Single passes; last slot 7 and 0 first, then random
        for (int i = 0; i < 6; i++) begin
            logic [2:0] ls;
            bit t;
            ls = (i == 0) ? 3'h7 : (i == 1 ? 3'h0 : 3'($urandom));
            t = i[0];
            d = 24'($urandom);
            ext = 8'($urandom);
            wr(`ADCSQ_ADDR_CHMAP, d);
            fork
                wait_n(ls + 1);
                wr(`ADCSQ_ADDR_CTRL, t ? (24'h003001 | 24'(ls) << 16) : (24'h000003 | 24'(ls) << 4));
            join
            repeat (30) @(negedge clk);
            chk({20'h0, busy, ls}, {21'h0, 3'(res_q.size() - 1)});
            foreach (res_q[k]) chk({16'h0, res_q[k]}, {16'h0, t, 3'(k), exp_ch(d, ext, k)});
        end
        $display("test single pass done");
        // Both requests at once: touch pass first, then general
        fork
            wait_n(5);
            wr(`ADCSQ_ADDR_CTRL, 24'h023013);
        join
        chk({22'h0, res_q[0][7], res_q[3][7]}, 24'h2);
        wr(`ADCSQ_ADDR_CTRL, 24'h0);
        $display("test priority done");
        // Delays: baseline at zero, then random values, for both sequences
        for (int t = 0; t < 2; t++) begin
            dv = '{4'h0, 4'h0, 4'h0};
            dly_run(t[0], b);
            dv = '{4'(1 + $urandom % 15), 4'(1 + $urandom % 15), 4'(1 + $urandom % 15)};
            dly_run(t[0], g);
            chk(in_rng(g[0] - b[0], dv[0]), 24'h1);
            chk(in_rng(g[1] - b[1], dv[1]), 24'h1);
            chk(in_rng(g[2] - b[2], dv[2]), 24'h1);
        end
        $display("test delays done");
        // Pause holds a continuous run, release resumes it
        for (int t = 0; t < 2; t++) begin
            int n;
            fork
                wait_n(2);
                wr(`ADCSQ_ADDR_CTRL, t ? 24'h007001 : 24'h000007);
            join
            wr(`ADCSQ_ADDR_CTRL, t ? 24'h00D001 : 24'h00000D);
            repeat (10) @(negedge clk);
            n = st_q.size();
            repeat (40) @(negedge clk);
            chk(24'(st_q.size() - n), 24'h0);
            wr(`ADCSQ_ADDR_CTRL, t ? 24'h005001 : 24'h000005);
            repeat (40) @(negedge clk);
            chk(24'(st_q.size() > n), 24'h1);
            rst_pulse();
        end
        $display("test pause done");
        stop_test();
    end
endmodule
